// ---- logic/rfid_cfg_pkg.sv ----
/*
  Shared constants of the reader configuration register bank: register
  offsets, reset and preset values, command codes and timing figures.
  Assumes a 125 MHz core clock and a 5-bit register address.
*/
`default_nettype none
package rfid_cfg_pkg;
  // Register offsets
  localparam logic [4:0] OFF_CHIP_STATUS_CONTROL   = 5'h00;
  localparam logic [4:0] OFF_PROTOCOL_SELECT       = 5'h01;
  localparam logic [4:0] OFF_TYPE_B_TX_OPTIONS     = 5'h02;
  localparam logic [4:0] OFF_TYPE_A_HIGH_RATE      = 5'h03;
  localparam logic [4:0] OFF_TX_TIMER_HIGH         = 5'h04;
  localparam logic [4:0] OFF_TX_TIMER_LOW          = 5'h05;
  localparam logic [4:0] OFF_TX_PULSE_LENGTH       = 5'h06;
  localparam logic [4:0] OFF_RX_NO_RESPONSE_WAIT   = 5'h07;
  localparam logic [4:0] OFF_RX_WAIT_TIME          = 5'h08;
  localparam logic [4:0] OFF_MODULATOR_CLOCK       = 5'h09;
  localparam logic [4:0] OFF_RX_SPECIAL_SETTING    = 5'h0a;
  localparam logic [4:0] OFF_REGULATOR_IO_CONTROL  = 5'h0b;
  localparam logic [4:0] OFF_IRQ_STATUS            = 5'h0c;
  localparam logic [4:0] OFF_COLLISION_IRQ_MASK    = 5'h0d;
  localparam logic [4:0] OFF_COLLISION_POSITION    = 5'h0e;
  localparam logic [4:0] OFF_SPECIAL_FUNCTION_A    = 5'h10;
  localparam logic [4:0] OFF_SPECIAL_FUNCTION_B    = 5'h11;
  localparam logic [4:0] OFF_FIFO_IRQ_LEVELS       = 5'h14;
  localparam logic [4:0] OFF_TEST_A                = 5'h1a;
  localparam logic [4:0] OFF_TEST_B                = 5'h1b;
  localparam logic [4:0] OFF_FIFO_STATUS           = 5'h1c;
  localparam logic [4:0] OFF_TX_LENGTH_FIRST       = 5'h1d;
  localparam logic [4:0] OFF_TX_LENGTH_SECOND      = 5'h1e;
  localparam logic [4:0] OFF_FIFO_PORT             = 5'h1f;

  // Reset values
  localparam logic [7:0] RST_CHIP_STATUS_CONTROL = 8'h01;
  localparam logic [7:0] RST_PROTOCOL_SELECT     = 8'h02;
  localparam logic [7:0] RST_PLAIN               = 8'h00;

  // Control and protocol register bit positions
  localparam int BIT_STANDBY       = 7;
  localparam int BIT_RAW_MODE      = 6;
  localparam int BIT_CARRIER_ON    = 5;
  localparam int BIT_HALF_POWER    = 4;
  localparam int BIT_AGC_ON        = 2;
  localparam int BIT_RX_FORCE      = 1;
  localparam int BIT_RAW_MODE_TYPE = 6;
  localparam int BIT_PROTO_CLASS   = 3;

  // System clock output divider bits, kept through a protocol preset
  localparam logic [7:0] SYSCLK_DIV_MASK = 8'h30;
  localparam int         BIT_SYSCLK_DIV0 = 4;

  // Low-level option presets
  localparam logic [7:0] PRESET_OPTION_PLAIN  = 8'h00;
  localparam logic [7:0] PRESET_TX_TIMER_LOW  = 8'hc1;
  localparam logic [7:0] PRESET_PULSE_NEAR    = 8'h20;
  localparam logic [7:0] PRESET_PULSE_FAR     = 8'h80;
  localparam logic [7:0] PRESET_NO_RESP_WAIT  = 8'h14;
  localparam logic [7:0] PRESET_RX_WAIT       = 8'h1f;
  localparam logic [7:0] PRESET_MODULATOR     = 8'h01;
  localparam logic [7:0] PRESET_RX_SPECIAL    = 8'h40;
  localparam logic [7:0] PRESET_REGULATOR     = 8'h87;

  // Commands
  localparam logic [4:0] CMD_GAIN_ADJUST = 5'h1a;

  // Timing
  localparam int CLK_MHZ          = 125;
  localparam int GAIN_INTERVAL_MS = 100;
  localparam int GAIN_CYCLES      = GAIN_INTERVAL_MS * 1000 * CLK_MHZ;
  localparam int WAKE_TIME_US     = 100;
  localparam int WAKE_CYCLES      = WAKE_TIME_US * CLK_MHZ;
  localparam logic [1:0] SENS_STEP_MAX = 2'h3;

  // Gain adjust sequencer states
  typedef enum logic [1:0] {
    GAIN_IDLE    = 2'b01,
    GAIN_MEASURE = 2'b10
  } gain_state_e;

  function automatic logic is_mapped(input logic [4:0] a);
    case (a)
      OFF_CHIP_STATUS_CONTROL, OFF_PROTOCOL_SELECT, OFF_TYPE_B_TX_OPTIONS,
      OFF_TYPE_A_HIGH_RATE, OFF_TX_TIMER_HIGH, OFF_TX_TIMER_LOW,
      OFF_TX_PULSE_LENGTH, OFF_RX_NO_RESPONSE_WAIT, OFF_RX_WAIT_TIME,
      OFF_MODULATOR_CLOCK, OFF_RX_SPECIAL_SETTING, OFF_REGULATOR_IO_CONTROL,
      OFF_IRQ_STATUS, OFF_COLLISION_IRQ_MASK, OFF_COLLISION_POSITION,
      OFF_SPECIAL_FUNCTION_A, OFF_SPECIAL_FUNCTION_B, OFF_FIFO_IRQ_LEVELS,
      OFF_TEST_A, OFF_TEST_B, OFF_FIFO_STATUS, OFF_TX_LENGTH_FIRST,
      OFF_TX_LENGTH_SECOND, OFF_FIFO_PORT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic is_read_only(input logic [4:0] a);
    is_read_only = (a == OFF_IRQ_STATUS) || (a == OFF_COLLISION_POSITION) ||
                   (a == OFF_FIFO_STATUS);
  endfunction

  function automatic logic is_option(input logic [4:0] a);
    is_option = (a >= OFF_TYPE_B_TX_OPTIONS) && (a <= OFF_REGULATOR_IO_CONTROL);
  endfunction

  // Protocol dependent preset of one low-level option register
  function automatic logic [7:0] preset_value(input logic [4:0] a,
                                              input logic [7:0] proto);
    case (a)
      OFF_TX_TIMER_LOW:         preset_value = PRESET_TX_TIMER_LOW;
      OFF_TX_PULSE_LENGTH:      preset_value = proto[BIT_PROTO_CLASS] ?
                                               PRESET_PULSE_NEAR : PRESET_PULSE_FAR;
      OFF_RX_NO_RESPONSE_WAIT:  preset_value = PRESET_NO_RESP_WAIT;
      OFF_RX_WAIT_TIME:         preset_value = PRESET_RX_WAIT;
      OFF_MODULATOR_CLOCK:      preset_value = PRESET_MODULATOR;
      OFF_RX_SPECIAL_SETTING:   preset_value = PRESET_RX_SPECIAL;
      OFF_REGULATOR_IO_CONTROL: preset_value = PRESET_REGULATOR;
      default:                  preset_value = PRESET_OPTION_PLAIN;
    endcase
  endfunction

  function automatic logic [7:0] reset_value(input logic [4:0] a);
    if (a == OFF_CHIP_STATUS_CONTROL) reset_value = RST_CHIP_STATUS_CONTROL;
    else if (a == OFF_PROTOCOL_SELECT) reset_value = RST_PROTOCOL_SELECT;
    else if (is_option(a)) reset_value = preset_value(a, RST_PROTOCOL_SELECT);
    else reset_value = RST_PLAIN;
  endfunction
endpackage
`default_nettype wire

// ---- logic/rfid_reader_config_regs.sv ----
/*
  Configuration and control register bank of the reader front end, with
  the receiver gain adjust sequencer and the standby wake-up timer.
  Assumes the host port decoder delivers one-cycle read, write and command
  strobes synchronous to ref_clk_i, and that all inputs are synchronous.
*/
// How it works
// - Count receive edges, raise threshold above two
// - Repeat until fewer than two edges counted, or noisy at step three
// - One step per raise, at most three
// - Enable low or reset restores full sensitivity
// - Power-up or enable rise loads default protocol
// - Protocol write presets all option registers
// - Host may override options after preset
// - Clock divider bits survive protocol preset
// - Control register is 0x01 under enable low
// - Bit 7 standby, wake after 100 us
// - Bit 6 raw mode, type from protocol
// - Bit 5 switches carrier and receivers
// - Power bit set selects half power
// - Special and test registers reset zero, RW
// - Power bit clear selects full power
// - Bit 1 forces receiver and oscillator on
// - Bit 2 enables AGC with its setting
// - Protocol register resets to 0x02
`default_nettype none
module rfid_reader_config_regs
  import rfid_cfg_pkg::*;
#(
  parameter int GAIN_INTERVAL = GAIN_CYCLES,
  parameter int WAKE_DELAY    = WAKE_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       enable_pin_i,
  input  wire logic [4:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [4:0] cmd_code_i,
  input  wire logic       rx_digital_i,
  input  wire logic [7:0] irq_status_i,
  input  wire logic [7:0] collision_position_i,
  input  wire logic [7:0] fifo_status_i,
  output logic      [7:0] reg_rdata_o,
  output logic            standby_o,
  output logic            active_ready_o,
  output logic            raw_mode_o,
  output logic            raw_mode_type_o,
  output logic            carrier_output_enable_o,
  output logic            receivers_on_o,
  output logic            tx_osc_force_o,
  output logic            half_power_select_o,
  output logic            agc_enable_o,
  output logic      [7:0] agc_setting_o,
  output logic      [1:0] sysclk_divider_o,
  output logic      [1:0] sensitivity_step_o,
  output logic            gain_adjust_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] reg_q [32];
  logic       enable_prev;
  logic       write_ok;
  logic       proto_write;
  logic       en_rise;
  logic       preset_now;
  logic [7:0] preset_proto;

  // Writes count only while the part is enabled
  assign write_ok     = reg_write_i & enable_pin_i;
  assign proto_write  = write_ok & (reg_addr_i == OFF_PROTOCOL_SELECT);
  assign en_rise      = enable_pin_i & ~enable_prev;
  assign preset_now   = proto_write | en_rise;
  assign preset_proto = proto_write ? reg_wdata_i : reg_q[OFF_PROTOCOL_SELECT];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      enable_prev <= 1'b1;                                             // Reset loads defaults
    end else begin
      enable_prev <= enable_pin_i;
    end
  end

  for (genvar i = 0; i < 32; i++) begin : g_reg
    localparam logic [4:0] A = 5'(i);
    if (is_mapped(A) && !is_read_only(A)) begin : g_rw
      localparam logic [7:0] KEEP = (A == OFF_MODULATOR_CLOCK) ? SYSCLK_DIV_MASK : 8'h00;
      localparam logic       MAIN = (A == OFF_CHIP_STATUS_CONTROL) ||
                                    (A == OFF_PROTOCOL_SELECT);
      logic [7:0] val;
      logic [7:0] next_val;
      logic       hit;
      assign hit = write_ok & (reg_addr_i == A);
      // Divider bits are merged back so a preset never disturbs them
      assign next_val = (preset_value(A, preset_proto) & ~KEEP) | (val & KEEP);
      // A register write lands after any earlier preset; a preset wipes it
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          val <= reset_value(A);
        end else if (MAIN && !enable_pin_i) begin
          val <= reset_value(A);
        end else if (hit) begin
          val <= reg_wdata_i;
        end else if (preset_now && is_option(A)) begin
          val <= next_val;
        end
      end
      assign reg_q[i] = val;
    end else if (A == OFF_IRQ_STATUS) begin : g_irq
      assign reg_q[i] = irq_status_i;
    end else if (A == OFF_COLLISION_POSITION) begin : g_coll
      assign reg_q[i] = collision_position_i;
    end else if (A == OFF_FIFO_STATUS) begin : g_fifo
      assign reg_q[i] = fifo_status_i;
    end else begin : g_none
      assign reg_q[i] = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] next_rdata;

  // Unmapped addresses decode to the zero entries of the array
  assign next_rdata = reg_read_i ? reg_q[reg_addr_i] : reg_rdata_o;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver gain adjust sequencer

  gain_state_e gain_state;
  gain_state_e next_gain_state;
  logic [23:0] gain_timer;
  logic [1:0]  edge_cnt;
  logic [1:0]  sens_step;
  logic        rx_prev;
  logic        interval_end;
  logic        noisy;
  logic        quiet;
  logic        gain_start;

  // Starting is trusted to the host, which checks the field is quiet
  assign gain_start   = cmd_valid_i & (cmd_code_i == CMD_GAIN_ADJUST) &
                        enable_pin_i;
  assign interval_end = (gain_state == GAIN_MEASURE) && (gain_timer == 24'h000000);
  assign noisy        = (edge_cnt == 2'h3);
  assign quiet        = (edge_cnt < 2'h2);

  // Exactly two edges neither raises nor stops; measurement repeats
  always_comb begin
    next_gain_state = gain_state;
    case (gain_state)
      GAIN_IDLE: begin
        if (gain_start) next_gain_state = GAIN_MEASURE;
      end
      GAIN_MEASURE: begin
        if (interval_end && (quiet || (noisy && sens_step == SENS_STEP_MAX))) begin
          next_gain_state = GAIN_IDLE;
        end
      end
      default: next_gain_state = GAIN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !enable_pin_i) begin
      gain_state <= GAIN_IDLE;
      sens_step  <= 2'h0;
    end else begin
      gain_state <= next_gain_state;
      if (interval_end && noisy && sens_step != SENS_STEP_MAX) begin
        sens_step <= sens_step + 2'h1;
      end
    end
  end

  // Interval timer and saturating edge counter, restarted each interval
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gain_timer <= 24'h000000;
      edge_cnt   <= 2'h0;
      rx_prev    <= 1'b0;
    end else begin
      rx_prev <= rx_digital_i;
      if (gain_state != GAIN_MEASURE || interval_end) begin
        gain_timer <= 24'(GAIN_INTERVAL - 1);
        edge_cnt   <= 2'h0;
      end else begin
        gain_timer <= gain_timer - 24'h000001;
        if ((rx_digital_i ^ rx_prev) && edge_cnt != 2'h3) begin
          edge_cnt <= edge_cnt + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standby wake-up timer

  logic [7:0]  ctrl;
  logic [7:0]  proto;
  logic [13:0] wake_cnt;

  assign ctrl  = reg_q[OFF_CHIP_STATUS_CONTROL];
  assign proto = reg_q[OFF_PROTOCOL_SELECT];

  // Held loaded in standby so the full delay runs after leaving it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wake_cnt <= 14'h0000;
    end else if (ctrl[BIT_STANDBY]) begin
      wake_cnt <= 14'(WAKE_DELAY);
    end else if (wake_cnt != 14'h0000) begin
      wake_cnt <= wake_cnt - 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      standby_o               <= 1'b0;
      active_ready_o          <= 1'b0;
      raw_mode_o              <= 1'b0;
      raw_mode_type_o         <= 1'b0;
      carrier_output_enable_o <= 1'b0;
      receivers_on_o          <= 1'b0;
      tx_osc_force_o          <= 1'b0;
      half_power_select_o     <= 1'b0;
      agc_enable_o            <= 1'b0;
      agc_setting_o           <= 8'h00;
      sysclk_divider_o        <= 2'h0;
      sensitivity_step_o      <= 2'h0;
      gain_adjust_busy_o      <= 1'b0;
    end else begin
      standby_o               <= ctrl[BIT_STANDBY];
      active_ready_o          <= !ctrl[BIT_STANDBY] && wake_cnt == 14'h0000;
      raw_mode_o              <= ctrl[BIT_RAW_MODE];
      raw_mode_type_o         <= proto[BIT_RAW_MODE_TYPE];
      carrier_output_enable_o <= ctrl[BIT_CARRIER_ON];
      receivers_on_o          <= ctrl[BIT_CARRIER_ON] | ctrl[BIT_RX_FORCE];
      tx_osc_force_o          <= ctrl[BIT_RX_FORCE];
      half_power_select_o     <= ctrl[BIT_HALF_POWER];
      agc_enable_o            <= ctrl[BIT_AGC_ON];
      agc_setting_o           <= ctrl[BIT_AGC_ON] ?
                                 reg_q[OFF_RX_SPECIAL_SETTING] : 8'h00;
      sysclk_divider_o        <= reg_q[OFF_MODULATOR_CLOCK][BIT_SYSCLK_DIV0 +: 2];
      sensitivity_step_o      <= sens_step;
      gain_adjust_busy_o      <= (gain_state == GAIN_MEASURE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Enable pin low holds the main registers and the gain logic at reset
  a_ctrl_enable_low: assert property (
    !enable_pin_i |=> ctrl == RST_CHIP_STATUS_CONTROL)
    else $error("control register not 0x01 while enable low");
  a_proto_enable_low: assert property (!enable_pin_i |=> proto == RST_PROTOCOL_SELECT)
    else $error("protocol register not default while enable low");
  a_gain_enable_low: assert property (!enable_pin_i |=> ##1 sensitivity_step_o == 2'h0)
    else $error("sensitivity step not cleared by enable low");

  // Gain adjust: one step per noisy interval; a clear by enable low is exempt
  a_step_single: assert property (
    $past(rst_n_i) && $past(enable_pin_i) && sens_step != $past(sens_step)
    |-> sens_step == $past(sens_step) + 2'h1)
    else $error("sensitivity moved by other than one step");
  a_raise_noisy: assert property (
    interval_end && noisy && sens_step != SENS_STEP_MAX && enable_pin_i
    |=> sens_step == $past(sens_step) + 2'h1)
    else $error("noisy interval did not raise threshold");
  a_stop_quiet: assert property (
    interval_end && quiet && enable_pin_i
    |=> gain_state == GAIN_IDLE ##1 !gain_adjust_busy_o)
    else $error("quiet interval did not end gain adjust");

  // Presets watched on the registers, where the preset edge shows at once
  a_preset_load: assert property (
    proto_write |=> reg_q[OFF_TX_PULSE_LENGTH] ==
    preset_value(OFF_TX_PULSE_LENGTH, $past(reg_wdata_i)))
    else $error("protocol write did not preset option");
  a_divider_keep: assert property (
    proto_write |=> $stable(reg_q[OFF_MODULATOR_CLOCK] & SYSCLK_DIV_MASK))
    else $error("divider bits changed by protocol preset");
  a_enable_rise: assert property (
    en_rise && !(write_ok && reg_addr_i == OFF_RX_WAIT_TIME)
    |=> reg_q[OFF_RX_WAIT_TIME] == PRESET_RX_WAIT)
    else $error("enable rise did not load default preset");
  a_option_override: assert property (
    write_ok && is_option(reg_addr_i) |=> reg_q[$past(reg_addr_i)] == $past(reg_wdata_i))
    else $error("option register write did not land");
  a_test_reg_write: assert property (
    write_ok && reg_addr_i == OFF_TEST_A |=> reg_q[OFF_TEST_A] == $past(reg_wdata_i))
    else $error("test register write did not land");

  // Output pins follow the control bits one clock later; unmapped reads return zero
  a_carrier_follow: assert property (
    ##1 carrier_output_enable_o == $past(ctrl[BIT_CARRIER_ON]))
    else $error("carrier output does not follow control bit");
  a_power_follow: assert property (
    ##1 half_power_select_o == $past(ctrl[BIT_HALF_POWER]))
    else $error("power select does not follow control bit");
  a_receivers_follow: assert property (
    ##1 receivers_on_o == $past(ctrl[BIT_CARRIER_ON] | ctrl[BIT_RX_FORCE]))
    else $error("receivers do not follow control bits");
  a_agc_follow: assert property (
    ##1 agc_setting_o ==
    ($past(ctrl[BIT_AGC_ON]) ? $past(reg_q[OFF_RX_SPECIAL_SETTING]) : 8'h00))
    else $error("gain setting does not follow control bit");
  a_raw_follow: assert property (
    ##1 raw_mode_o == $past(ctrl[BIT_RAW_MODE]))
    else $error("raw mode does not follow control bit");
  a_standby_ready: assert property (
    ctrl[BIT_STANDBY] |=> ##1 !active_ready_o)
    else $error("ready shown while in standby");
  a_unmapped_zero: assert property (
    reg_read_i && !is_mapped(reg_addr_i) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned nonzero");

  // Main scenarios that the bench is expected to reach
  c_gain_raise: cover property (interval_end && noisy && sens_step != SENS_STEP_MAX);
  c_option_override: cover property (write_ok && is_option(reg_addr_i));
  c_gain_saturate: cover property (sens_step == SENS_STEP_MAX);
  c_protocol_preset: cover property (proto_write);
  c_wake_from_standby: cover property ($fell(standby_o) ##[1:3] !active_ready_o);

endmodule
`default_nettype wire

// ---- tb/host_port_model.sv ----
/*
  Host side model: register port, command strobe, enable pin and noisy rx.
  Assumes the bench clock; every request starts and ends on a rising edge.
*/
`default_nettype none
module host_port_model (
  input  wire logic       clk_i,
  output logic            enable_pin_o,
  output logic [4:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            write_o,
  output logic            read_o,
  output logic            cmd_valid_o,
  output logic [4:0]      cmd_code_o,
  output logic            rx_o,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       noise_on;
  logic [2:0] noise_cnt;
  initial begin
    {enable_pin_o, write_o, read_o, cmd_valid_o, rx_o, noise_on} = 6'b100000;
    {addr_o, cmd_code_o, wdata_o, noise_cnt} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Noise: an edge every 8 cycles, well above two per measurement interval
  always @(posedge clk_i) begin
    noise_cnt <= noise_cnt + 3'h1;
    if (noise_on && noise_cnt == 3'h0) rx_o <= ~rx_o;
  end
  // Strobes last exactly one cycle, address held until the taking edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i) {write_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge clk_i) write_o <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i) {read_o, addr_o} <= {1'b1, a};
    @(posedge clk_i) read_o <= 1'b0;
    @(posedge clk_i) #1 d = rdata_i;
  endtask
  task automatic cmd(input logic [4:0] c);
    @(posedge clk_i) {cmd_valid_o, cmd_code_o} <= {1'b1, c};
    @(posedge clk_i) cmd_valid_o <= 1'b0;
  endtask
  task automatic pulse_enable_low();
    @(posedge clk_i) enable_pin_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    enable_pin_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/rfid_reader_config_regs_tb_top.sv ----
/*
  Self-checking bench for the register bank; short interval and wake counts.
  Assumes the host model above drives every request.
*/
`default_nettype none
module rfid_reader_config_regs_tb_top
  import rfid_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GI = 50;
  localparam int WD = 10;
  logic       ref_clk_i, rst_n_i, en, wr_s, rd_s, cv, rx, busy, rdy;
  logic       stby, raw, rtype, car, rcv, osc, half, agc;
  logic [4:0] addr, code;
  logic [7:0] wdata, rdata, agc_set, d, ctl;
  logic [1:0] div, step;
  int         num_errors, checks;
  logic [4:0] ta [10] = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h10, 5'h11, 5'h1a, 5'h1b, 5'h0c, 5'h15};
  logic [7:0] te [10] = '{8'h01, 8'h02, 8'hc1, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00};
  assign ctl = {car, rcv, osc, half, agc, stby, raw, rtype};
  host_port_model host (.clk_i(ref_clk_i), .enable_pin_o(en), .addr_o(addr), .wdata_o(wdata),
    .write_o(wr_s), .read_o(rd_s), .cmd_valid_o(cv), .cmd_code_o(code), .rx_o(rx),
    .rdata_i(rdata));
  rfid_reader_config_regs #(.GAIN_INTERVAL(GI), .WAKE_DELAY(WD)) uut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .enable_pin_i(en), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr_s), .reg_read_i(rd_s), .cmd_valid_i(cv), .cmd_code_i(code),
    .rx_digital_i(rx), .irq_status_i(8'h5a), .collision_position_i(8'h3c),
    .fifo_status_i(8'h0f), .reg_rdata_o(rdata), .standby_o(stby), .active_ready_o(rdy),
    .raw_mode_o(raw), .raw_mode_type_o(rtype), .carrier_output_enable_o(car),
    .receivers_on_o(rcv), .tx_osc_force_o(osc), .half_power_select_o(half),
    .agc_enable_o(agc), .agc_setting_o(agc_set), .sysclk_divider_o(div),
    .sensitivity_step_o(step), .gain_adjust_busy_o(busy));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, comparison and closing helpers
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chk(input logic [4:0] a, input logic [7:0] e);
    host.rd(a, d);
    check($sformatf("reg %h", a), d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Bounded wait so a sequencer that never stops is caught, not hung on
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) tick(1);
  endtask
  task automatic final_report();
    $display("Counts: %0d checks, %0d errors", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(20000);
    num_errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst_n_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    host.wr(5'h15, 8'ha5);
    host.wr(5'h0c, 8'h33);
    foreach (ta[i]) chk(ta[i], te[i]);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      host.wr(ta[i+4], 8'ha0 | 8'(i));
      chk(ta[i+4], 8'ha0 | 8'(i));
    end
    $display("test read write done");
    host.wr(5'h00, 8'h36);
    tick(1);
    check("ctl", ctl, 8'b11111000);
    check("agc", agc_set, 8'h40);
    host.wr(5'h00, 8'h02);
    tick(1);
    check("ctl", ctl, 8'b01100000);
    check("agc", agc_set, 8'h00);
    host.wr(5'h01, 8'h42);
    host.wr(5'h00, 8'h40);
    tick(1);
    check("ctl", ctl, 8'b00000011);
    $display("test control bits done");
    host.wr(5'h09, 8'h35);
    host.wr(5'h05, 8'h55);
    chk(5'h05, 8'h55);
    check("div", {6'h0, div}, 8'h03);
    host.wr(5'h01, 8'h08);
    chk(5'h05, 8'hc1);
    chk(5'h06, 8'h20);
    chk(5'h09, 8'h31);
    host.wr(5'h01, 8'h02);
    chk(5'h06, 8'h80);
    $display("test preset done");
    host.wr(5'h01, 8'h08);
    host.wr(5'h05, 8'h55);
    host.wr(5'h00, 8'h20);
    host.pulse_enable_low();
    chk(5'h00, 8'h01);
    chk(5'h01, 8'h02);
    chk(5'h05, 8'hc1);
    chk(5'h06, 8'h80);
    $display("test enable done");
    host.wr(5'h00, 8'h80);
    tick(WD);
    check("sleep", {6'h0, stby, rdy}, 8'h02);
    host.wr(5'h00, 8'h00);
    tick(WD / 2);
    check("wake early", {7'h0, rdy}, 8'h00);
    tick(WD);
    check("wake", {7'h0, rdy}, 8'h01);
    $display("test standby done");
    host.wr(5'h00, 8'h20);
    host.noise_on <= 1'b1;
    host.cmd(CMD_GAIN_ADJUST);
    tick(3);
    check("busy", {7'h0, busy}, 8'h01);
    wait_idle(6 * GI);
    host.noise_on = 1'b0;
    check("steps", {busy, 5'h0, step}, 8'h03);
    host.pulse_enable_low();
    tick(1);
    check("steps", {6'h0, step}, 8'h00);
    host.wr(5'h00, 8'h20);
    host.cmd(CMD_GAIN_ADJUST);
    tick(3);
    check("busy", {7'h0, busy}, 8'h01);
    wait_idle(2 * GI + 10);
    check("quiet", {busy, 5'h0, step}, 8'h00);
    $display("test gain adjust done");
    final_report();
  end
endmodule
`default_nettype wire
